// ### design/lbps_device.sv
/*
  Device end: filters the combined enable/brightness input, drives the LED
  string switch and the main power switch, and steps the peak current limit.
  Assumes comparator and protection inputs are synchronous to mclk.
*/
// Function
// - Enable after input high 50 us
// - Input low 32 ms shuts down
// - Lows under 10 ms never shut down
// - Rising edge closes LED switch at once
// - Ignore feedback 400 ns after closing
// - Feedback below reference turns switch on
// - Peak current reached turns switch off
// - Maximum on-time 6 us forces off
// - Off at least 400 ns and feedback low
// - Limit quarter, half, full per 256 cycles
// - Soft start done after 512 cycles
// - Host high phase over 2.5 us early
// - Host high phase over 400 ns later
// - Host frequency 100 Hz to 50 kHz; lbps_host does not bound it and takes any periodCycles
// - Host duty 1% to 100%; lbps_host does not bound it, and highCycles 0 gives 0%
// - Host never leaves input floating
// - Overvoltage holds main switch off
// - Undervoltage opens both switches
// - Thermal shutdown opens both switches
module lbps_device
  import lbps_pkg::*;
#(
  parameter int SHUTDOWN_COUNT = SHUTDOWN_CYC,
  parameter int ENABLE_COUNT   = ENABLE_CYC
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Host link
  lbps_link.device        link,
  // Comparator and protection inputs
  input  wire logic       fbBelowRef,
  input  wire logic       peakReached,
  input  wire logic       overvoltageGuard,
  input  wire logic       underVoltage,
  input  wire logic       thermalShutdown,
  // Switch commands and status
  output logic            mainPowerSwitch,
  output logic            ledStringSwitch,
  output logic [1:0]      peakCurrentLimit,
  output logic            deviceEnabled
);
  typedef struct packed {
    lbps_dev_state_t dev;
    lbps_sw_state_t  sw;
    logic            prevIn;
    logic [31:0]     highCnt;
    logic [31:0]     lowCnt;
    logic [3:0]      blankCnt;
    logic [7:0]      onCnt;
    logic [3:0]      offCnt;
    logic [9:0]      ssCnt;
    logic            mainSw;
    logic            ledSw;
    logic [1:0]      limit;
    logic            ssDone;
  } lbps_dev_regs_t;

  lbps_dev_regs_t r_q;
  lbps_dev_regs_t r_d;
  logic           inHigh;
  logic           fault;

  assign inHigh = link.brightEnable;
  assign fault  = underVoltage | thermalShutdown;

  always_comb begin
    r_d = r_q;
    r_d.prevIn = inHigh;
    r_d.highCnt = inHigh ? ((r_q.highCnt < 32'(ENABLE_COUNT)) ? r_q.highCnt + 32'h1 : r_q.highCnt) : 32'h0;
    r_d.lowCnt = inHigh ? 32'h0 : ((r_q.lowCnt < 32'(SHUTDOWN_COUNT)) ? r_q.lowCnt + 32'h1 : r_q.lowCnt);
    if (r_q.blankCnt != 4'h0) begin
      r_d.blankCnt = r_q.blankCnt - 4'h1;
    end
    case (r_q.dev)
      DEV_OFF: begin
        r_d.mainSw = 1'b0;
        r_d.ledSw = 1'b0;
        r_d.sw = SW_IDLE;
        r_d.ssCnt = 10'h0;
        r_d.ssDone = 1'b0;
        r_d.limit = LIMIT_OFF;
        // A saturated count still enables, so a fault that clears under a steady high input restarts.
        if (r_q.highCnt >= 32'(ENABLE_COUNT - 1) && inHigh && !fault) begin
          r_d.dev = DEV_RUN;
          r_d.ledSw = 1'b1;
          r_d.limit = LIMIT_QUARTER;
          r_d.blankCnt = 4'(BLANK_CYC);
        end
      end
      DEV_RUN: begin
        // The LED switch tracks the input; a closing restarts the blanking window.
        if (inHigh && !r_q.prevIn) begin
          r_d.ledSw = 1'b1;
          r_d.blankCnt = 4'(BLANK_CYC);
        end else if (!inHigh) begin
          r_d.ledSw = 1'b0;
        end
        case (r_q.sw)
          SW_IDLE: begin
            if (fbBelowRef && r_q.blankCnt == 4'h0 && !overvoltageGuard) begin
              r_d.sw = SW_ON;
              r_d.mainSw = 1'b1;
              r_d.onCnt = 8'h0;
              if (r_q.ssCnt != 10'(SS_DONE_CYCLES)) begin
                r_d.ssCnt = r_q.ssCnt + 10'h1;
              end
            end
          end
          SW_ON: begin
            r_d.onCnt = r_q.onCnt + 8'h1;
            if (peakReached || r_q.onCnt == 8'(MAX_ON_CYC - 1) || overvoltageGuard) begin
              r_d.sw = SW_OFFTIME;
              r_d.mainSw = 1'b0;
              r_d.offCnt = 4'(MIN_OFF_CYC - 1);
            end
          end
          SW_OFFTIME: begin
            r_d.offCnt = r_q.offCnt - 4'h1;
            if (r_q.offCnt == 4'h0) begin
              r_d.sw = SW_IDLE;
            end
          end
          default: r_d.sw = SW_IDLE;
        endcase
        if (r_q.ssCnt < 10'(SS_STEP_CYCLES)) begin
          r_d.limit = LIMIT_QUARTER;
        end else if (r_q.ssCnt < 10'(SS_DONE_CYCLES)) begin
          r_d.limit = LIMIT_HALF;
        end else begin
          r_d.limit = LIMIT_FULL;
          r_d.ssDone = 1'b1;
        end
        // Shutdown on a fault, or once the low phase passes 32 ms, which is also beyond 10 ms.
        if (fault || r_q.lowCnt == 32'(SHUTDOWN_COUNT - 1) && !inHigh) begin
          r_d.dev = DEV_OFF;
          r_d.mainSw = 1'b0;
          r_d.ledSw = 1'b0;
          r_d.ssCnt = 10'h0;
          r_d.ssDone = 1'b0;
          r_d.limit = LIMIT_OFF;
          r_d.sw = SW_IDLE;
        end
      end
      default: r_d.dev = DEV_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '{dev: DEV_OFF, sw: SW_IDLE, limit: LIMIT_OFF, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign mainPowerSwitch   = r_q.mainSw;
  assign ledStringSwitch   = r_q.ledSw;
  assign peakCurrentLimit  = r_q.limit;
  assign deviceEnabled     = (r_q.dev == DEV_RUN);
  assign link.softStartDone = r_q.ssDone;
endmodule

// ### design/lbps_pkg.sv
/*
  Package for the LED boost sequencer: timing constants, soft start steps,
  limit codes and state encodings shared by the device end and the host end.
  Assumes a 20 MHz mclk shared by both ends.
*/
package lbps_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int NS_PER_S = 1_000_000_000;

  localparam int ENABLE_US = 50;
  localparam int ENABLE_CYC = (ENABLE_US * (CLK_HZ / 1_000_000));
  localparam int SHUTDOWN_MS = 32;
  localparam int SHUTDOWN_CYC = SHUTDOWN_MS * (CLK_HZ / 1000);
  localparam int SHUTDOWN_MIN_MS = 10;
  localparam int SHUTDOWN_MIN_CYC = SHUTDOWN_MIN_MS * (CLK_HZ / 1000);
  localparam int BLANK_NS = 400;
  localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MAX_ON_NS = 6000;
  localparam int MAX_ON_CYC = (MAX_ON_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int MIN_OFF_NS = 400;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam int SS_STEP_CYCLES = 256;
  localparam int SS_DONE_CYCLES = 512;

  localparam int HOST_HIGH_SS_NS = 2500;
  localparam int HOST_HIGH_SS_CYC = (HOST_HIGH_SS_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + 1;
  localparam int HOST_HIGH_RUN_NS = 400;
  localparam int HOST_HIGH_RUN_CYC = (HOST_HIGH_RUN_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + 1;

  localparam logic [1:0] LIMIT_OFF = 2'h0;
  localparam logic [1:0] LIMIT_QUARTER = 2'h1;
  localparam logic [1:0] LIMIT_HALF = 2'h2;
  localparam logic [1:0] LIMIT_FULL = 2'h3;

  typedef enum logic [1:0] {DEV_OFF, DEV_RUN} lbps_dev_state_t;
  typedef enum logic [1:0] {SW_IDLE, SW_ON, SW_OFFTIME} lbps_sw_state_t;
endpackage

// ### design/lbps_link.sv
/*
  Link between the host brightness source and the device sequencer.
  Assumes both ends share mclk; brightEnable is driven by the host only, softStartDone by the device.
*/
interface lbps_link;
  logic brightEnable;
  logic softStartDone;

  modport device (input brightEnable, output softStartDone);
  modport host (output brightEnable, input softStartDone);
endinterface

// ### design/lbps_host.sv
/*
  Host end: a PWM brightness source. Period and high time are user inputs in
  mclk cycles; a nonzero high time is stretched to the legal minimum for the phase.
  Assumes the device reports soft start completion on the link.
*/
module lbps_host
  import lbps_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // User controls
  input  wire logic        run,
  input  wire logic [19:0] periodCycles,
  input  wire logic [19:0] highCycles,
  // Link
  lbps_link.host           link
);
  typedef struct packed {
    logic [19:0] cnt;
    logic        out;
  } lbps_host_regs_t;

  lbps_host_regs_t r_q;
  lbps_host_regs_t r_d;
  logic [19:0]     minHigh;
  logic [19:0]     useHigh;

  // Stretching the high phase keeps it legal; the duty bound is the user's concern.
  always_comb begin
    minHigh = link.softStartDone ? 20'(HOST_HIGH_RUN_CYC) : 20'(HOST_HIGH_SS_CYC);
    useHigh = (highCycles >= periodCycles) ? periodCycles :
              ((highCycles != 20'h0 && highCycles < minHigh) ? minHigh : highCycles);
    r_d = r_q;
    if (!run) begin
      r_d.cnt = 20'h0;
      r_d.out = 1'b0;
    end else begin
      r_d.cnt = (r_q.cnt + 20'h1 >= periodCycles) ? 20'h0 : r_q.cnt + 20'h1;
      r_d.out = (r_d.cnt < useHigh);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign link.brightEnable = r_q.out;
endmodule

// ### test/lbps_props.sv
/*
  Checker for the link and the device outputs of the LED boost sequencer.
  Assumes one mclk domain and the shortened counts set by tb.
*/
module lbps_props
  import lbps_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  // Link
  input wire logic       brightEnable,
  input wire logic       softStartDone,
  // Comparator and protection inputs
  input wire logic       fbBelowRef,
  input wire logic       peakReached,
  input wire logic       overvoltageGuard,
  input wire logic       underVoltage,
  input wire logic       thermalShutdown,
  // Device outputs
  input wire logic       mainPowerSwitch,
  input wire logic       ledStringSwitch,
  input wire logic [1:0] peakCurrentLimit,
  input wire logic       deviceEnabled
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_UV: assert property (underVoltage[*2] |-> !mainPowerSwitch && !ledStringSwitch)
    else $error("undervoltage left a switch closed");
  AST_TS: assert property (thermalShutdown[*2] |-> !mainPowerSwitch && !ledStringSwitch)
    else $error("thermal fault left a switch closed");
  AST_OV: assert property (overvoltageGuard[*2] |-> !mainPowerSwitch)
    else $error("main switch on above overvoltage");
  AST_ENA: assert property ($rose(deviceEnabled) |-> $past(brightEnable, 15) && $past(brightEnable))
    else $error("enabled without a long high input");
  AST_SHORT: assert property (deviceEnabled && !underVoltage && !thermalShutdown && $fell(brightEnable)
    |-> deviceEnabled[*8])
    else $error("short low phase shut the device down");
  AST_MAXON: assert property ($rose(mainPowerSwitch) |-> ##[1:125] !mainPowerSwitch)
    else $error("main switch exceeded the on-time limit");
  AST_MINOFF: assert property ($fell(mainPowerSwitch) |-> !mainPowerSwitch[*7])
    else $error("main switch reopened inside the off-time");
  AST_FBON: assert property ($rose(mainPowerSwitch) |-> $past(fbBelowRef))
    else $error("main switch on without low feedback");
  AST_LED: assert property ($rose(brightEnable) && deviceEnabled && !underVoltage && !thermalShutdown
    |=> ##[0:1] ledStringSwitch)
    else $error("LED switch missed a rising input");
  // A turn-on already launched with the closing edge is allowed, hence the one-cycle offset.
  AST_BLANK: assert property ($rose(ledStringSwitch) |=> !$rose(mainPowerSwitch)[*7])
    else $error("main switch turned on inside the blanking window");

  cover property ($rose(deviceEnabled));
  cover property ($rose(softStartDone));
  cover property ($fell(deviceEnabled));
endmodule

// ### test/tb.sv
/*
  Bench joining the host end and the device end over the link.
  Assumes the shortened enable and shutdown counts given below.
*/
module tb
  import lbps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0, resetn = 0, run = 0, fbLow = 0, peak = 0, overvoltage_guard = 0, uvp = 0, hot = 0;
  logic        mainSw, ledSw, enabled;
  logic [1:0]  limit;
  logic [19:0] period = 20'h64, high = 20'h64;
  int          nFail = 0, testsRun = 0, onCyc = 0;

  always #25 mclk = ~mclk;
  lbps_link link ();
  lbps_host i_lbps_host (.mclk(mclk), .resetn(resetn), .run(run), .periodCycles(period),
    .highCycles(high), .link(link));
  lbps_device #(.SHUTDOWN_COUNT(200), .ENABLE_COUNT(20)) i_lbps_device (.mclk(mclk), .resetn(resetn),
    .link(link), .fbBelowRef(fbLow), .peakReached(peak), .overvoltageGuard(overvoltage_guard), .underVoltage(uvp),
    .thermalShutdown(hot), .mainPowerSwitch(mainSw), .ledStringSwitch(ledSw),
    .peakCurrentLimit(limit), .deviceEnabled(enabled));
  lbps_props i_props (.mclk(mclk), .resetn(resetn), .brightEnable(link.brightEnable),
    .softStartDone(link.softStartDone), .fbBelowRef(fbLow), .peakReached(peak), .overvoltageGuard(overvoltage_guard),
    .underVoltage(uvp), .thermalShutdown(hot), .mainPowerSwitch(mainSw), .ledStringSwitch(ledSw),
    .peakCurrentLimit(limit), .deviceEnabled(enabled));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check(input logic seen, input logic exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (nFail == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One switch cycle; without a peak report the on-time limit must end it.
  task automatic pulse(input logic usePeak);
    fbLow <= 1'b1;
    for (int i = 0; i < 40 && mainSw !== 1'b1; i++) tick(1);
    fbLow <= 1'b0;
    peak <= usePeak;
    onCyc = 0;
    for (int i = 0; i < 200 && mainSw === 1'b1; i++) begin
      tick(1);
      onCyc++;
    end
    peak <= 1'b0;
    tick(10);
  endtask
  task automatic t_enable();
    run <= 1'b1;
    for (int i = 0; i < 100 && enabled !== 1'b1; i++) tick(1);
    tick(1);
    check(enabled, 1'b1);
    check(limit === LIMIT_QUARTER, 1'b1);
  endtask
  task automatic t_softstart();
    for (int n = 1; n <= 512; n++) begin
      pulse(1'b1);
      if (n == 1) check(onCyc <= 2, 1'b1);
      if (n == 255) check(limit === LIMIT_QUARTER, 1'b1);
      if (n == 256) check(limit === LIMIT_HALF, 1'b1);
      if (n == 511) check(link.softStartDone, 1'b0);
    end
    check(link.softStartDone, 1'b1);
    check(limit === LIMIT_FULL, 1'b1);
  endtask
  task automatic t_maxon();
    pulse(1'b0);
    check(onCyc >= MAX_ON_CYC - 2 && onCyc <= MAX_ON_CYC + 2, 1'b1);
  endtask
  task automatic t_pwm();
    period <= 20'h12c;
    high <= 20'hfa;
    repeat (4) begin
      @(posedge link.brightEnable);
      tick(2);
      check(ledSw, 1'b1);
      check(enabled, 1'b1);
    end
    run <= 1'b0;
    tick(300);
    check(enabled, 1'b0);
    check(ledSw, 1'b0);
    period <= 20'h64;
    high <= 20'h64;
    run <= 1'b1;
    tick(60);
    check(enabled, 1'b1);
    check(link.softStartDone, 1'b0);
  endtask
  task automatic t_fault();
    for (int f = 0; f < 3; f++) begin
      overvoltage_guard <= f == 0;
      uvp <= f == 1;
      hot <= f == 2;
      fbLow <= 1'b1;
      tick(30);
      check(mainSw, 1'b0);
      check(ledSw, f == 0);
      overvoltage_guard <= 1'b0;
      uvp <= 1'b0;
      hot <= 1'b0;
      tick(30);
      if (f == 0) check(mainSw, 1'b1);
      fbLow <= 1'b0;
      tick(150);
    end
  endtask

  initial begin
    tick(6);
    resetn <= 1'b1;
    tick(2);
    t_enable();
    t_softstart();
    t_maxon();
    t_pwm();
    t_fault();
    results();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    nFail++;
    results();
  end
endmodule
